// ===== cler_pkg.sv
// Shared constants and carrier types for clock-loss / enable / reset control
package cler_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ              = 20_000_000;
   localparam int unsigned LOSS_THRESHOLD_NS   = 2000;
   localparam int unsigned LOSS_THRESHOLD_CYC  = (LOSS_THRESHOLD_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned POR_TIME_US         = 100;
   localparam int unsigned POR_TIME_CYC        = POR_TIME_US * (CLK_HZ / 1_000_000);

   // ----------------------------------------
   // Divider and reset values
   // ----------------------------------------
   localparam int unsigned DIV_W               = 4;
   localparam logic [3:0]  DIV_RESET           = 4'h8;
   localparam logic [3:0]  DIV_MIN             = 4'h1;
   localparam int unsigned SYNC_STAGES         = 3;

   typedef enum logic [1:0]
   {
      CLER_RUN     = 2'b00,
      CLER_LOST    = 2'b01,
      CLER_TRIPPED = 2'b10
   } cler_wd_state_t;

   // Host configuration write carrier
   typedef struct packed
   {
      logic       wrDivider;
      logic [3:0] divRatio;
      logic       wdEnable;
      logic       wrChanEn;
      logic [1:0] chanEn;
      logic       enFaultMask;
   } cler_cfg_t;

   // Status carrier
   typedef struct packed
   {
      logic       inReset;
      logic       wdStatus;
      logic       rstOccurred;
      logic       clockAbsent;
      logic       portEnable;
   } cler_stat_t;

endpackage

// ===== cler_sync.sv
// Three-stage synchroniser for pin inputs with agreement-based change detection
`timescale 1ns/1ps
module cler_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Change accepted only when the two later stages agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               level[i] <= 1'b0;
            else if (stage2[i] == stage3[i])
               level[i] <= stage3[i];
         end
      end
   endgenerate

endmodule

// ===== cler_control.sv
// Clock-loss watchdog, enable pin and reset control of a two-channel driver
`timescale 1ns/1ps
module cler_control
#(
   parameter int unsigned LOSS_CYC = cler_pkg::LOSS_THRESHOLD_CYC,
   parameter int unsigned POR_CYC  = cler_pkg::POR_TIME_CYC
)
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 clkPin,
   input  wire logic                 enablePin,
   input  wire logic                 extResetPin_n,
   input  wire logic                 diagFault,
   input  wire logic                 diagAccess,
   input  wire logic                 cfgValid,
   input  wire cler_pkg::cler_cfg_t  cfg,
   output cler_pkg::cler_stat_t      stat,
   output logic [3:0]                divRatio,
   output logic                      wdEnable,
   output logic [1:0]                chanEn,
   output logic                      outputsEnabled,
   output logic                      sysTick,
   output logic                      replyVersionOnly,
   output logic                      faultOut,
   output logic                      faultOe_n
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   logic [2:0] pinLevel;
   logic       clkLevel;
   logic       enLevel;
   logic       resLevel_n;

   cler_sync #(.WIDTH(3)) u_sync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .pinIn ({clkPin, enablePin, extResetPin_n}),
      .level (pinLevel)
   );

   assign clkLevel   = pinLevel[2];
   assign enLevel    = pinLevel[1];
   assign resLevel_n = pinLevel[0];

   logic clkPrev;
   logic clkRise;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clkPrev <= 1'b0;
      else
         clkPrev <= clkLevel;
   end

   assign clkRise = clkLevel & ~clkPrev;

   // ----------------------------------------
   // Power-on timer and reset state
   // ----------------------------------------
   logic [31:0] porCount;
   logic        porDone;
   logic        extResetHeld;
   logic        inReset;
   logic        resetPrev;

   // POR counts on the local clock after supply-good (rst_n) release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         porCount <= '0;
      else if (porCount < POR_CYC)
         porCount <= porCount + 32'h1;
   end

   assign porDone      = (porCount >= POR_CYC);
   assign extResetHeld = ~resLevel_n;

   cler_pkg::cler_wd_state_t wdState;

   assign inReset = ~porDone | extResetHeld | (wdState != cler_pkg::CLER_RUN);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         resetPrev <= 1'b1;
      else
         resetPrev <= inReset;
   end

   // ----------------------------------------
   // Clock-loss watchdog
   // ----------------------------------------
   logic [31:0] gapCount;
   logic        lossNow;
   logic        wdStatus;

   // Local clock measures the gap so a dead pin clock is still seen
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         gapCount <= '0;
      else if (clkRise)
         gapCount <= '0;
      else if (gapCount <= LOSS_CYC)
         gapCount <= gapCount + 32'h1;
   end

   assign lossNow = (gapCount > LOSS_CYC);

   // Tripped state returns to RUN only by external reset pin or power-on reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wdState <= cler_pkg::CLER_RUN;
      else if (extResetHeld)
         wdState <= cler_pkg::CLER_RUN;
      else
      begin
         unique case (wdState)
            cler_pkg::CLER_RUN:
               if (wdEnable && lossNow)
                  wdState <= cler_pkg::CLER_LOST;
            cler_pkg::CLER_LOST:
               if (!lossNow)
                  wdState <= cler_pkg::CLER_TRIPPED;
            cler_pkg::CLER_TRIPPED:
               if (lossNow)
                  wdState <= cler_pkg::CLER_LOST;
            default:
               wdState <= cler_pkg::CLER_TRIPPED;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wdStatus <= 1'b0;
      else if (extResetHeld)
         wdStatus <= 1'b0;
      else if (wdState == cler_pkg::CLER_RUN && wdEnable && lossNow)
         wdStatus <= 1'b1;
   end

   // ----------------------------------------
   // Configuration bits
   // ----------------------------------------
   logic writeOk;
   logic divWritten;

   assign writeOk = cfgValid & ~inReset;

   // Reset state also restores divider to 8 after a trip
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divRatio   <= cler_pkg::DIV_RESET;
         wdEnable   <= 1'b0;
         divWritten <= 1'b0;
      end
      else if (inReset)
      begin
         divRatio   <= cler_pkg::DIV_RESET;
         wdEnable   <= 1'b0;
         divWritten <= 1'b0;
      end
      else if (writeOk && cfg.wrDivider)
      begin
         divRatio   <= (cfg.divRatio < cler_pkg::DIV_MIN) ? cler_pkg::DIV_MIN : cfg.divRatio;
         wdEnable   <= cfg.wdEnable;
         divWritten <= 1'b1;
      end
   end

   logic enMask;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         enMask <= 1'b0;
      else if (inReset)
         enMask <= 1'b0;
      else if (writeOk && cfg.wrChanEn)
         enMask <= cfg.enFaultMask;
   end

   // Enable pin low clears bits; they return only by a new write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         chanEn <= 2'h0;
      else if (inReset || !enLevel)
         chanEn <= 2'h0;
      else if (writeOk && cfg.wrChanEn)
         chanEn <= cfg.chanEn;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         outputsEnabled <= 1'b0;
      else
         outputsEnabled <= ~inReset & divWritten & wdEnable & enLevel;
   end

   // ----------------------------------------
   // System clock divider on pin clock edges
   // ----------------------------------------
   logic [3:0] divCount;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         divCount <= 4'h0;
         sysTick  <= 1'b0;
      end
      else
      begin
         sysTick <= 1'b0;
         if (clkRise)
         begin
            if (divCount >= divRatio - 4'h1)
            begin
               divCount <= 4'h0;
               sysTick  <= 1'b1;
            end
            else
               divCount <= divCount + 4'h1;
         end
      end
   end

   // ----------------------------------------
   // Status, reply select and fault pin
   // ----------------------------------------
   logic rstOccurred;

   // Set wins over a clearing access in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rstOccurred <= 1'b0;
      else if (resetPrev && !inReset)
         rstOccurred <= 1'b1;
      else if (diagAccess)
         rstOccurred <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         replyVersionOnly <= 1'b0;
         faultOut         <= 1'b0;
         faultOe_n        <= 1'b0;
      end
      else
      begin
         replyVersionOnly <= lossNow;
         faultOut         <= 1'b0;
         // Watchdog trip is part of inReset, so the mask cannot hide it
         faultOe_n <= ~(diagFault | inReset | (~enLevel & enMask));
      end
   end

   assign stat = '{inReset:     inReset,
                   wdStatus:    wdStatus,
                   rstOccurred: rstOccurred,
                   clockAbsent: lossNow,
                   portEnable:  ~extResetHeld & porDone};

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_trip_fault: assert property (@(posedge clk) disable iff (!rst_n)
      (wdState == cler_pkg::CLER_RUN && wdEnable && lossNow && !extResetHeld)
         |=> ##1 (!faultOe_n && !outputsEnabled && wdStatus))
      else $error("Watchdog trip did not pull fault low");

   a_trip_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (wdState == cler_pkg::CLER_TRIPPED && !extResetHeld)
         |=> (wdState != cler_pkg::CLER_RUN))
      else $error("Watchdog reset released without external reset");

   a_div_reset: assert property (@(posedge clk) disable iff (!rst_n)
      (wdState == cler_pkg::CLER_TRIPPED) |=> (divRatio == cler_pkg::DIV_RESET))
      else $error("Divider not back at eight after trip");

   a_wd_gate_out: assert property (@(posedge clk) disable iff (!rst_n)
      (!wdEnable || !divWritten) |=> !outputsEnabled)
      else $error("Outputs enabled without watchdog or divider");

   a_en_clears: assert property (@(posedge clk) disable iff (!rst_n)
      !enLevel |=> (chanEn == 2'h0))
      else $error("Channel enables not cleared by enable pin");

   a_en_stay_low: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(enLevel) && !(cfgValid && cfg.wrChanEn)) |=> (chanEn == 2'h0))
      else $error("Channel enables rose without a write");

   a_ignore_wr: assert property (@(posedge clk) disable iff (!rst_n)
      (inReset && cfgValid) |=> (!wdEnable && divRatio == cler_pkg::DIV_RESET))
      else $error("Write accepted during reset");

   // Fault pin is registered, so it follows the held reset one edge later
   a_ext_reset: assert property (@(posedge clk) disable iff (!rst_n)
      extResetHeld |-> (inReset && !stat.portEnable) ##1 !faultOe_n)
      else $error("External reset not honoured");

   a_rst_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (resetPrev && !inReset) |=> rstOccurred)
      else $error("Reset flag not set on reset exit");

   a_mask_fault: assert property (@(posedge clk) disable iff (!rst_n)
      (!enLevel && enMask) |=> !faultOe_n)
      else $error("Enable pin fault not signalled");

   c_trip:    cover property (@(posedge clk) wdState == cler_pkg::CLER_TRIPPED);
   c_running: cover property (@(posedge clk) outputsEnabled);
   c_enfall:  cover property (@(posedge clk) $fell(enLevel) && chanEn != 2'h0);
   c_tick:    cover property (@(posedge clk) sysTick);

endmodule

// ===== cler_host_model.sv
// Host controller model driving the control pins of the clock-loss block
`timescale 1ns/1ps
module cler_host_model
(
   input  wire logic           clk,
   output logic                clkPin,
   output logic                enablePin,
   output logic                extResetPin_n,
   output logic                diagAccess,
   output logic                cfgValid,
   output cler_pkg::cler_cfg_t cfg
);
   logic clkRun;
   logic phase;

   initial
   begin
      clkRun        = 1'b0;
      phase         = 1'b0;
      clkPin        = 1'b0;
      enablePin     = 1'b1;
      extResetPin_n = 1'b1;
      diagAccess    = 1'b0;
      cfgValid      = 1'b0;
      cfg           = '0;
   end

   // ----------------------------------------
   // Pin clock, one rising edge every four local cycles
   // ----------------------------------------
   // Stopped clock sits at the pull-down level
   always @(negedge clk)
   begin
      phase <= clkRun ? ~phase : 1'b0;
      if (!clkRun)
         clkPin <= 1'b0;
      else if (phase)
         clkPin <= ~clkPin;
   end

   task automatic run_clock(input logic on);
      clkRun = on;
   endtask

   // ----------------------------------------
   // Control actions
   // ----------------------------------------
   // Writes issued whatever the reset state; the block drops them while in reset
   task automatic write(input cler_pkg::cler_cfg_t c);
      @(negedge clk);
      cfgValid = 1'b1;
      cfg      = c;
      @(negedge clk);
      cfgValid = 1'b0;
      // Idle bus carries garbage, not the last value
      cfg      = ~c;
   endtask

   task automatic diag_access();
      @(negedge clk);
      diagAccess = ~diagAccess;
      @(negedge clk);
      diagAccess = ~diagAccess;
   endtask

   // Only host action that clears a watchdog trip; rst_n also clears it
   task automatic reset_pulse(input int n);
      @(negedge clk);
      extResetPin_n = 1'b0;
      repeat (n) @(negedge clk);
      extResetPin_n = 1'b1;
   endtask

   task automatic set_enable(input logic v);
      @(negedge clk);
      enablePin = v;
   endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the clock-loss, enable and reset control block
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
   localparam int unsigned LOSS = 8;
   localparam int unsigned POR  = 20;

   logic                 clk;
   logic                 rst_n;
   logic                 diagFault;
   logic                 clkPin;
   logic                 enablePin;
   logic                 extResetPin_n;
   logic                 diagAccess;
   logic                 cfgValid;
   cler_pkg::cler_cfg_t  cfg;
   cler_pkg::cler_stat_t stat;
   logic [3:0]           divRatio;
   logic                 wdEnable;
   logic [1:0]           chanEn;
   logic                 outputsEnabled;
   logic                 sysTick;
   logic                 replyVersionOnly;
   logic                 faultOut;
   logic                 faultOe_n;
   int                   errors;
   int                   checked;

   cler_control #(.LOSS_CYC(LOSS), .POR_CYC(POR)) dut
   (
      .clk(clk), .rst_n(rst_n), .clkPin(clkPin), .enablePin(enablePin),
      .extResetPin_n(extResetPin_n), .diagFault(diagFault), .diagAccess(diagAccess),
      .cfgValid(cfgValid), .cfg(cfg), .stat(stat), .divRatio(divRatio),
      .wdEnable(wdEnable), .chanEn(chanEn), .outputsEnabled(outputsEnabled),
      .sysTick(sysTick), .replyVersionOnly(replyVersionOnly), .faultOut(faultOut),
      .faultOe_n(faultOe_n)
   );

   cler_host_model host
   (
      .clk(clk), .clkPin(clkPin), .enablePin(enablePin), .extResetPin_n(extResetPin_n),
      .diagAccess(diagAccess), .cfgValid(cfgValid), .cfg(cfg)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (stat.inReset !== 1'b0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      `CHECK(stat.inReset, 1'b0)
      // Registered outputs and the reset flag follow one edge later
      @(negedge clk);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_reset();
      `CHECK(faultOe_n, 1'b0)
      `CHECK(stat.inReset, 1'b1)
      wait_ready();
      `CHECK(divRatio, 4'h8)
      `CHECK(wdEnable, 1'b0)
      `CHECK(stat.rstOccurred, 1'b1)
      `CHECK(faultOe_n, 1'b1)
      `CHECK(faultOut, 1'b0)
      host.diag_access();
      cycles(1);
      `CHECK(stat.rstOccurred, 1'b0)
      diagFault = ~diagFault;
      cycles(2);
      `CHECK(faultOe_n, 1'b0)
      diagFault = ~diagFault;
      cycles(2);
      `CHECK(faultOe_n, 1'b1)
   endtask

   task automatic test_gate();
      int ticks;
      host.write('{1'b0, 4'h0, 1'b0, 1'b1, 2'h3, 1'b0});
      cycles(3);
      `CHECK(chanEn, 2'h3)
      `CHECK(outputsEnabled, 1'b0)
      host.write('{1'b1, 4'h4, 1'b0, 1'b0, 2'h0, 1'b0});
      cycles(3);
      `CHECK(outputsEnabled, 1'b0)
      cycles(3 * LOSS);
      `CHECK(stat.wdStatus, 1'b0)
      `CHECK(stat.inReset, 1'b0)
      host.run_clock(1'b1);
      // Pin edges must be seen before arming, or the old gap trips at once
      cycles(2 * LOSS);
      `CHECK(replyVersionOnly, 1'b0)
      `CHECK(stat.clockAbsent, 1'b0)
      host.write('{1'b1, 4'h4, 1'b1, 1'b0, 2'h0, 1'b0});
      `CHECK(wdEnable, 1'b1)
      `CHECK(divRatio, 4'h4)
      cycles(2);
      `CHECK(outputsEnabled, 1'b1)
      ticks = 0;
      repeat (160)
      begin
         @(posedge clk);
         #1 if (sysTick === 1'b1) ticks++;
      end
      `CHECK(ticks inside {9, 10, 11}, 1'b1)
      `CHECK(stat.wdStatus, 1'b0)
   endtask

   task automatic test_enable();
      host.set_enable(1'b0);
      cycles(6);
      `CHECK(chanEn, 2'h0)
      `CHECK(outputsEnabled, 1'b0)
      `CHECK(divRatio, 4'h4)
      `CHECK(faultOe_n, 1'b1)
      host.write('{1'b0, 4'h0, 1'b0, 1'b1, 2'h3, 1'b1});
      cycles(2);
      `CHECK(chanEn, 2'h0)
      `CHECK(faultOe_n, 1'b0)
      host.set_enable(1'b1);
      cycles(6);
      `CHECK(chanEn, 2'h0)
      `CHECK(outputsEnabled, 1'b1)
      host.write('{1'b0, 4'h0, 1'b0, 1'b1, 2'h2, 1'b0});
      cycles(1);
      `CHECK(chanEn, 2'h2)
   endtask

   task automatic test_watchdog();
      host.run_clock(1'b0);
      cycles(LOSS + 10);
      `CHECK(stat.wdStatus, 1'b1)
      `CHECK(faultOe_n, 1'b0)
      `CHECK(outputsEnabled, 1'b0)
      `CHECK(stat.inReset, 1'b1)
      `CHECK(replyVersionOnly, 1'b1)
      `CHECK(stat.clockAbsent, 1'b1)
      host.write('{1'b1, 4'h3, 1'b1, 1'b1, 2'h1, 1'b0});
      cycles(1);
      `CHECK(divRatio, 4'h8)
      host.run_clock(1'b1);
      cycles(40);
      `CHECK(divRatio, 4'h8)
      `CHECK(wdEnable, 1'b0)
      `CHECK(chanEn, 2'h0)
      `CHECK(stat.wdStatus, 1'b1)
      `CHECK(stat.inReset, 1'b1)
      host.write('{1'b1, 4'h3, 1'b1, 1'b1, 2'h1, 1'b0});
      host.diag_access();
      cycles(2);
      `CHECK(divRatio, 4'h8)
      `CHECK(stat.inReset, 1'b1)
      host.reset_pulse(10);
      `CHECK(stat.portEnable, 1'b0)
      `CHECK(faultOe_n, 1'b0)
      wait_ready();
      `CHECK(stat.wdStatus, 1'b0)
      `CHECK(stat.rstOccurred, 1'b1)
      `CHECK(faultOe_n, 1'b1)
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      errors    = 0;
      checked   = 0;
      rst_n     = 1'b0;
      diagFault = 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      test_reset();
      test_gate();
      test_enable();
      test_watchdog();
      results();
   end

   initial
   begin
      #(50 * 5000);
      errors++;
      results();
   end
endmodule
